/* soe_cfg_chk.sv */
// assertion checker for the configuration/status word ports
`timescale 1ns/1ns
module soe_cfg_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        module_run,
    input wire logic        internal_err,
    input wire logic        chatter_ctl_en
);
    wire acc = psel && penable;
    wire cfg = paddr == soe_pkg::CFG_STAT_OFF;
    wire wr  = acc && pwrite && cfg;
    wire hit = cfg || paddr inside {soe_pkg::IRQ_STAT_OFF, soe_pkg::IRQ_MASK_OFF,
                                    soe_pkg::CHAT_STAT_OFF};
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready)
        else $error("pready low");
    unused_zero_a: assert property (acc && !pwrite && cfg |-> prdata[31:15] == 17'h00000
        && prdata[5:2] == 4'h0) else $error("unused status bits set");
    force_err_a: assert property (wr |=> internal_err == $past(pwdata[1]))
        else $error("force bit not applied");
    chat_en_a: assert property (wr |=> chatter_ctl_en != $past(pwdata[12]))
        else $error("chatter enable wrong");
    run_halt_a: assert property (internal_err && $past(internal_err) |-> !module_run)
        else $error("running under forced error");
    bad_addr_a: assert property (acc |-> pslverr == !hit)
        else $error("pslverr wrong");
    bad_data_a: assert property (acc && !pwrite && !hit |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    cover property (wr && pwdata[0]);
    cover property (acc && pslverr);
    cover property ($rose(module_run));
endmodule : soe_cfg_chk
bind soe_input_config_status_reg soe_cfg_chk chk_u (.*);

/* soe_chatter.sv */
// per-channel chatter detector
`timescale 1ns/1ns
module soe_chatter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        opt_burst,
    input  wire logic        win_tick,
    input  wire logic        buf_read,
    input  wire logic        in_level,
    output logic             chatter
);
    logic       prev_q;
    logic [2:0] cnt_q;
    logic       change;

    assign change = run && (in_level != prev_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= in_level;
        end
    end

    // change count; reset by buffer read with the burst option, by window tick without it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h0;
        end else if (!run) begin
            cnt_q <= 3'h0;
        end else if ((opt_burst && buf_read) || (!opt_burst && win_tick)) begin
            cnt_q <= change ? 3'h1 : 3'h0;
        end else if (change && cnt_q != 3'h7) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    assign chatter = opt_burst ? (cnt_q >= soe_pkg::CHAT_BURST) : (cnt_q > 3'h1);
endmodule : soe_chatter

/* soe_ctl_model.sv */
// controller model: apb master issuing register transfers
`timescale 1ns/1ns
module soe_ctl_model (
    input wire logic        pclk,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [11:0]     paddr,
    output logic [31:0]     pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= a == soe_pkg::CFG_STAT_OFF ? d & {16'h0, soe_pkg::CFG_WMASK} : d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : soe_ctl_model

/* soe_input_config_status_reg.sv */
// apb configuration/status word with fault flags, chatter control and interrupt
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module soe_input_config_status_reg (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fuse_blown,
    input  wire logic        aux_fail,
    input  wire logic        gnd_fault,
    input  wire logic        clk_sync,
    input  wire logic [15:0] chan_in,
    input  wire logic        event_buf_read,
    output logic             module_run,
    output logic             internal_err,
    output logic             external_err,
    output logic             attention,
    output logic             chatter_ctl_en,
    output logic [15:0]      chatter_flag,
    output logic             irq
);
    typedef enum logic [1:0] {
        SOE_IDLE = 2'b00,
        SOE_RUN  = 2'b01,
        SOE_ERR  = 2'b10
    } soe_state_t;

    soe_state_t  state_q;
    logic [15:0] cfg_q;
    logic [15:0] status;
    logic [4:0]  ista_q;
    logic [4:0]  imask_q;
    logic [4:0]  ev;
    logic [31:0] win_q;
    logic        win_tick;
    logic        fuse_q;
    logic        aux_q;
    logic        gnd_q;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic        chat_any;
    logic        attn;
    logic        ext_err;
    logic        attn_q;
    logic        ext_q;
    logic        irq_q;
    logic [15:0] chat_raw;
    logic [15:0] chat_q;

    function automatic logic dec(input logic [11:0] a, input logic [11:0] off);
        dec = (a == off);
    endfunction : dec

    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign hit    = dec(paddr, soe_pkg::CFG_STAT_OFF) || dec(paddr, soe_pkg::IRQ_STAT_OFF)
                 || dec(paddr, soe_pkg::IRQ_MASK_OFF) || dec(paddr, soe_pkg::CHAT_STAT_OFF);
    assign pslverr = psel && penable && !hit;

    // configuration register; unused bits dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= soe_pkg::CFG_RESET;
        end else if (wr_en && dec(paddr, soe_pkg::CFG_STAT_OFF)) begin
            cfg_q <= pwdata[15:0] & soe_pkg::CFG_WMASK;
        end
    end

    // operating state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SOE_IDLE;
        end else begin
            case (state_q)
                SOE_IDLE: begin
                    if (cfg_q[soe_pkg::B_CONFIGURE]) begin
                        // a forced error blocks the start
                        state_q <= cfg_q[soe_pkg::B_FORCE_ERR] ? SOE_ERR : SOE_RUN;
                    end
                end
                SOE_RUN: begin
                    if (!cfg_q[soe_pkg::B_CONFIGURE]) begin
                        state_q <= SOE_IDLE;
                    end else if (cfg_q[soe_pkg::B_FORCE_ERR]) begin
                        state_q <= SOE_ERR;
                    end
                end
                SOE_ERR: begin
                    if (!cfg_q[soe_pkg::B_FORCE_ERR]) begin
                        state_q <= cfg_q[soe_pkg::B_CONFIGURE] ? SOE_RUN : SOE_IDLE;
                    end
                end
                default: state_q <= SOE_IDLE;
            endcase
        end
    end

    assign module_run   = (state_q == SOE_RUN);
    assign internal_err = cfg_q[soe_pkg::B_FORCE_ERR];

    // supervision flags, one per fault; fuse gated by its enable, aux and ground both gated by the contact bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_q <= 1'b0;
        end else begin
            fuse_q <= cfg_q[soe_pkg::B_FUSE_EN] && fuse_blown;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_q <= 1'b0;
        end else begin
            aux_q <= cfg_q[soe_pkg::B_CONTACT] && aux_fail;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gnd_q <= 1'b0;
        end else begin
            gnd_q <= cfg_q[soe_pkg::B_CONTACT] && gnd_fault;
        end
    end

    assign ext_err = fuse_q || aux_q || gnd_q;
    assign attn = fuse_q || aux_q || (gnd_q && cfg_q[soe_pkg::B_GND_EN])
               || cfg_q[soe_pkg::B_FORCE_ERR];

    // error and attention outputs from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attn_q <= 1'b0;
        end else begin
            attn_q <= attn;
        end
    end

    assign external_err = ext_q;
    assign attention    = attn_q;

    // status word
    always_comb begin
        status = 16'h0000;
        status[soe_pkg::B_CONFIGURE] = cfg_q[soe_pkg::B_CONFIGURE];
        status[soe_pkg::B_FORCE_ERR] = cfg_q[soe_pkg::B_FORCE_ERR];
        status[soe_pkg::B_FUSE_EN]   = cfg_q[soe_pkg::B_FUSE_EN];
        status[soe_pkg::B_FUSE_FLT]  = fuse_q;
        status[soe_pkg::B_CONTACT]   = cfg_q[soe_pkg::B_CONTACT];
        status[soe_pkg::B_AUX_FAIL]  = aux_q;
        status[soe_pkg::B_GND_EN]    = cfg_q[soe_pkg::B_GND_EN];
        status[soe_pkg::B_GND_FLT]   = gnd_q;
        status[soe_pkg::B_CHAT_DIS]  = cfg_q[soe_pkg::B_CHAT_DIS];
        status[soe_pkg::B_CHAT_OPT]  = cfg_q[soe_pkg::B_CHAT_OPT];
        status[soe_pkg::B_CLK_SYNC]  = clk_sync;
    end

    // 100 ms window for rate-based chatter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_q <= 32'h0000_0000;
        end else if (!module_run || win_tick) begin
            win_q <= 32'h0000_0000;
        end else begin
            win_q <= win_q + 32'h0000_0001;
        end
    end

    assign win_tick = (win_q == 32'(soe_pkg::CHAT_WIN_CYC - 1));

    assign chatter_ctl_en = !cfg_q[soe_pkg::B_CHAT_DIS];

    for (genvar i = 0; i < 16; i++) begin : g_chat
        soe_chatter u_chat (
            .pclk      (pclk),
            .presetn   (presetn),
            .run       (module_run && chatter_ctl_en),
            .opt_burst (cfg_q[soe_pkg::B_CHAT_OPT]),
            .win_tick  (win_tick),
            .buf_read  (event_buf_read),
            .in_level  (chan_in[i]),
            .chatter   (chat_raw[i])
        );
    end

    // chatter flags from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chat_q <= 16'h0000;
        end else begin
            chat_q <= chat_raw;
        end
    end

    assign chatter_flag = chat_q;
    assign chat_any = |chat_raw;
    assign ev = {attn, chat_any, gnd_q, aux_q, fuse_q};

    // sticky events; set wins over clear-on-read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ista_q <= 5'h00;
        end else if (rd_en && dec(paddr, soe_pkg::IRQ_STAT_OFF)) begin
            ista_q <= ev;
        end else begin
            ista_q <= ista_q | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= soe_pkg::IRQ_MASK_RESET;
        end else if (wr_en && dec(paddr, soe_pkg::IRQ_MASK_OFF)) begin
            imask_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ista_q & imask_q);
        end
    end

    assign irq = irq_q;

    // read data registered at the end of the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                soe_pkg::CFG_STAT_OFF:  prdata <= {16'h0000, status};
                soe_pkg::IRQ_STAT_OFF:  prdata <= {27'h0000000, ista_q | ev};
                soe_pkg::IRQ_MASK_OFF:  prdata <= {27'h0000000, imask_q};
                soe_pkg::CHAT_STAT_OFF: prdata <= {16'h0000, chatter_flag};
                default:                prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : soe_input_config_status_reg

/* soe_pkg.sv */
// constants for the sequence-of-events configuration and status word
package soe_pkg;
    // register byte offsets
    localparam logic [11:0] CFG_STAT_OFF  = 12'h034;  // word index 13
    localparam logic [11:0] IRQ_STAT_OFF  = 12'h040;
    localparam logic [11:0] IRQ_MASK_OFF  = 12'h044;
    localparam logic [11:0] CHAT_STAT_OFF = 12'h048;
    localparam int          CFG_WORD_IDX  = 13;
    // configuration / status field positions
    localparam int B_CONFIGURE = 0;
    localparam int B_FORCE_ERR = 1;
    localparam int B_FUSE_EN   = 6;
    localparam int B_FUSE_FLT  = 7;
    localparam int B_CONTACT   = 8;
    localparam int B_AUX_FAIL  = 9;
    localparam int B_GND_EN    = 10;
    localparam int B_GND_FLT   = 11;
    localparam int B_CHAT_DIS  = 12;
    localparam int B_CHAT_OPT  = 13;
    localparam int B_CLK_SYNC  = 14;
    // writable configuration bits
    localparam logic [15:0] CFG_WMASK  = 16'h3543;
    localparam logic [15:0] CFG_RESET  = 16'h0000;
    // interrupt status layout
    localparam int I_FUSE    = 0;
    localparam int I_AUX     = 1;
    localparam int I_GND     = 2;
    localparam int I_CHATTER = 3;
    localparam int I_ATTN    = 4;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    // chatter timing
    localparam int  CLK_HZ       = 20000000;
    localparam int  CHAT_WIN_MS  = 100;
    localparam int  CHAT_WIN_CYC = CLK_HZ / 1000 * CHAT_WIN_MS;
    localparam logic [2:0] CHAT_BURST = 3'h4;
endpackage : soe_pkg

/* tb_top.sv */
// self-checking bench for the configuration/status word
`timescale 1ns/1ns
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, event_buf_read = 1'b0, e;
    logic        fuse_blown = 1'b0, aux_fail = 1'b0, gnd_fault = 1'b0, clk_sync = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, module_run, internal_err;
    logic        external_err, attention, chatter_ctl_en, irq;
    logic [11:0] paddr;
    logic [15:0] chan_in = 16'h0, chatter_flag, w;
    logic [31:0] pwdata, prdata, rd, xs_q = 32'hED0CE876;
    int          err_count = 0, total_checks = 0, cyc = 0;
    always #25 pclk = ~pclk;
    soe_ctl_model ctl_u (.*);
    soe_input_config_status_reg dut_u (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [15:0] stat(input logic [15:0] v);
        stat = v & soe_pkg::CFG_WMASK;
        stat[7] = fuse_blown & v[6];
        stat[9] = aux_fail & v[8];
        stat[11] = gnd_fault & v[8];
        stat[14] = clk_sync;
    endfunction : stat
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        total_checks++;
        if (s !== x) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        ctl_u.xfer(wr, a, d, rd, e);
    endtask : acc
    // toggle channel 0 n times, optionally after an event buffer read
    task automatic tog(input int n, input logic clr);
        @(posedge pclk);
        event_buf_read <= clr;
        @(posedge pclk);
        event_buf_read <= 1'b0;
        repeat (n) begin
            repeat (2) @(posedge pclk);
            chan_in <= chan_in ^ 16'h0001;
        end
        repeat (3) @(negedge pclk);
    endtask : tog
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn  <= 1'b1;
        clk_sync <= 1'b1;
        acc(1'b0, soe_pkg::CFG_STAT_OFF, 32'h0);
        chk("reset_status", {16'h0, stat(16'h0)}, rd);
        for (int i = 0; i < 20; i++) begin
            xs_q = xs(xs_q);
            w = i == 0 ? 16'hFFFF : xs_q[15:0];
            {fuse_blown, aux_fail, gnd_fault, clk_sync} <= xs_q[19:16];
            acc(1'b1, soe_pkg::CFG_STAT_OFF, {16'h0, w});
            acc(1'b0, soe_pkg::CFG_STAT_OFF, 32'h0);
            chk("status", {16'h0, stat(w)}, rd);
            chk("internal_err", w[1], internal_err);
            chk("chatter_ctl_en", !w[12], chatter_ctl_en);
            chk("module_run", w[0] && !w[1], module_run);
            chk("external_err", |(stat(w) & 16'h0A80), external_err);
            chk("attention", (fuse_blown & w[6]) | (aux_fail & w[8])
                | (gnd_fault & w[8] & w[10]) | w[1], attention);
        end
        acc(1'b1, 12'h0F0, 32'hFFFFFFFF);
        chk("pslverr_wr", 1'b1, e);
        acc(1'b0, 12'h0F0, 32'h0);
        chk("pslverr", 1'b1, e);
        chk("unmapped", 32'h0, rd);
        {fuse_blown, aux_fail, gnd_fault} <= 3'h0;
        acc(1'b1, soe_pkg::CFG_STAT_OFF, 32'h0041);
        acc(1'b0, soe_pkg::IRQ_STAT_OFF, 32'h0);
        fuse_blown <= 1'b1;
        tog(0, 1'b0);
        @(posedge pclk);
        fuse_blown <= 1'b0;
        tog(0, 1'b0);
        chk("irq_masked", 1'b0, irq);
        acc(1'b1, soe_pkg::IRQ_MASK_OFF, 32'h1);
        tog(0, 1'b0);
        chk("irq_set", 1'b1, irq);
        acc(1'b0, soe_pkg::IRQ_STAT_OFF, 32'h0);
        chk("irq_status", 32'h11, rd);
        tog(0, 1'b0);
        chk("irq_cleared", 1'b0, irq);
        acc(1'b1, soe_pkg::CFG_STAT_OFF, 32'h0001);
        tog(1, 1'b0);
        chk("chatter_one", 16'h0, chatter_flag);
        tog(1, 1'b0);
        chk("chatter_two", 16'h1, chatter_flag);
        acc(1'b1, soe_pkg::CFG_STAT_OFF, 32'h2001);
        tog(3, 1'b1);
        chk("burst_three", 16'h0, chatter_flag);
        tog(1, 1'b0);
        acc(1'b0, soe_pkg::CHAT_STAT_OFF, 32'h0);
        chk("burst_four", 32'h1, rd);
        acc(1'b1, soe_pkg::CFG_STAT_OFF, 32'h3001);
        tog(4, 1'b1);
        chk("chatter_off", 16'h0, chatter_flag);
        // reset again in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset_run", 1'b0, module_run);
        chk("reset_irq", 1'b0, irq);
        acc(1'b0, soe_pkg::CFG_STAT_OFF, 32'h0);
        chk("reset_again", {16'h0, stat(16'h0)}, rd);
        results();
    end
endmodule : tb_top
